// ### logic/pmsp_pkg.sv
// Package for the management serial slave port: command codes, field
// positions, constants and the carrier types.
// Assumes a single system clock domain and one link sampling clock.
package pmsp_pkg;
   // --------------------------------------------------------------------
   // Command codes
   // --------------------------------------------------------------------
   localparam logic [7:0] CMD_PAGE      = 8'h00;
   localparam logic [7:0] CMD_CLEAR     = 8'h03;
   localparam logic [7:0] CMD_ST_VOUT   = 8'h7a;
   localparam logic [7:0] CMD_ST_IOUT   = 8'h7b;
   localparam logic [7:0] CMD_ST_IN     = 8'h7c;
   localparam logic [7:0] CMD_ST_TEMP   = 8'h7d;
   localparam logic [7:0] CMD_ST_CML    = 8'h7e;
   localparam logic [7:0] CMD_VIN       = 8'h88;
   localparam logic [7:0] CMD_IIN       = 8'h89;
   localparam logic [7:0] CMD_VOUT      = 8'h8b;
   localparam logic [7:0] CMD_IOUT      = 8'h8c;
   localparam logic [7:0] CMD_TEMP      = 8'h8d;
   localparam logic [7:0] CMD_POUT      = 8'h96;
   localparam logic [7:0] CMD_PIN       = 8'h97;
   localparam logic [7:0] CMD_PWD_STORE = 8'ha7;
   localparam logic [7:0] CMD_ADDR_CFG  = 8'he1;
   localparam logic [7:0] CMD_BOOT_V    = 8'he5;
   localparam logic [7:0] CMD_PWD_CHECK = 8'hf2;
   // --------------------------------------------------------------------
   // Command attributes {supported, writable, readable, protected, bytes}
   // --------------------------------------------------------------------
   localparam logic [5:0] CI_PAGE = 6'h39;
   localparam logic [5:0] CI_SEND = 6'h30;
   localparam logic [5:0] CI_STAT = 6'h29;
   localparam logic [5:0] CI_TELE = 6'h2a;
   localparam logic [5:0] CI_PRW  = 6'h3e;
   localparam logic [5:0] CI_WO   = 6'h32;
   localparam int CI_SUP  = 5;
   localparam int CI_WR   = 4;
   localparam int CI_RD   = 3;
   localparam int CI_PROT = 2;
   // --------------------------------------------------------------------
   // Fields, constants
   // --------------------------------------------------------------------
   localparam int ADDR_LO_MODE = 7;
   localparam int ADDR_HI_MODE = 8;
   localparam int BOOT_ALT     = 8;
   localparam int CML_CMD      = 7;
   localparam int CML_DATA     = 6;
   localparam int CML_PEC      = 5;
   localparam int CML_OTHER    = 1;
   localparam logic [6:0]  ALL_CALL     = 7'h00;
   localparam logic [7:0]  CRC_POLY     = 8'h07;
   localparam logic [15:0] VID_OFF_ALT  = 16'h001d;
   localparam logic [15:0] VID_OFF_STD  = 16'h0031;
   localparam logic [15:0] STEP_10      = 16'h000a;
   localparam logic [15:0] STEP_5       = 16'h0005;
   // --------------------------------------------------------------------
   // Types
   // --------------------------------------------------------------------
   typedef struct packed {
      logic [15:0] vin, iin, vout, iout, temp, pout, pin;
      logic [7:0]  st_vout, st_iout, st_in, st_temp;
   } pmsp_tele_t;
   typedef enum logic [1:0] {S_IDLE, S_BYTE, S_SKIP} pmsp_state_t;
   typedef struct packed {
      pmsp_state_t st;
      logic [2:0]  scl, sda;
      logic [3:0]  hs1, hs2, ls1, ls2, bcnt;
      logic [15:0] pw1, pw2, wbuf, pwd, acfg, boot;
      logic [1:0]  ld;
      logic        ak1, ak2, req, rd, have_cmd, mnack, sda_o, sda_oe, locked, hw, prot;
      logic [2:0]  bidx, ndata, txi;
      logic [7:0]  sh, cmd, last, crc, crcp, txb, cml, page;
      logic [6:0]  addr;
   } pmsp_link_t;
   typedef struct packed {
      logic        alt1, alt2, rq1, rq2, ack;
      pmsp_tele_t  snap;
      logic [15:0] vout_mv;
   } pmsp_sys_t;
endpackage

// ### logic/pmsp_port.sv
// Management serial slave port: bus engine on the link clock, telemetry
// snapshot and voltage scaling on the system clock.
// Assumes SCL/SDA and straps are asynchronous pins; telemetry is mclk logic.
`timescale 1ns/1ns
// Behaviour
// - Serves 100 kHz, 400 kHz, 1 MHz bus rates
// - Seven-bit address from register or strap halves
// - All-call address zero refused when written with both mode bits set
// - Bit 7 clear: low nibble from low strap
// - Bit 8 clear: upper bits from high strap
// - High strap picks upper address and hardware protection
// - Voltage equals VID plus offset times step
// - Boot setting bit 8 selects alternate table
// - Byte count, read bit, command faults recorded
// - Clear command wipes communication faults
// - Send, byte, word reads/writes, optional PEC
// - PEC covers all bytes; act only when correct
// - CRC-8 polynomial x8 plus x2 plus x plus 1
// - Telemetry returned in fixed LSB scales
// - Status flags appear at 7Ah to 7Eh
// - Nonzero stored password locks until matched
// - Hardware strap protection overrides password
// - Protection blocks flagged registers only
module pmsp_port
   import pmsp_pkg::*;
(
   input  wire logic        mclk_in,
   input  wire logic        rst_in,
   input  wire logic        link_clk_in,
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe_out,
   input  wire logic [3:0]  high_address_strap_in,
   input  wire logic [3:0]  low_address_strap_in,
   input  wire logic [15:0] nvm_password_in,
   input  wire logic        voltage_code_step_10mv_in,
   input  wire pmsp_tele_t  tele_in,
   output logic [6:0]       device_address_out,
   output logic             protect_active_out,
   output logic             alt_table_out,
   output logic [15:0]      vout_mv_out
);
   // --------------------------------------------------------------------
   // State and helpers
   // --------------------------------------------------------------------
   pmsp_link_t  r, n;
   pmsp_sys_t   m, mn;
   logic        rise, fall, start, stop, exec, clr;
   logic [7:0]  setf, tb;
   logic [5:0]  ci, cb;
   logic [15:0] wd, vid;
   logic [2:0]  len;

   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] x;
      x = c ^ d;
      for (int i = 0; i < 8; i++) begin
         x = x[7] ? ({x[6:0], 1'b0} ^ CRC_POLY) : {x[6:0], 1'b0};
      end
      return x;
   endfunction

   function automatic logic [5:0] cinfo(input logic [7:0] c);
      case (c)
         CMD_PAGE:                        cinfo = CI_PAGE;
         CMD_CLEAR:                       cinfo = CI_SEND;
         CMD_ST_VOUT, CMD_ST_IOUT, CMD_ST_IN,
         CMD_ST_TEMP, CMD_ST_CML:         cinfo = CI_STAT;
         CMD_VIN, CMD_IIN, CMD_VOUT, CMD_IOUT,
         CMD_TEMP, CMD_POUT, CMD_PIN:     cinfo = CI_TELE;
         CMD_PWD_STORE, CMD_ADDR_CFG,
         CMD_BOOT_V:                      cinfo = CI_PRW;
         CMD_PWD_CHECK:                   cinfo = CI_WO;
         default:                         cinfo = 6'h00;
      endcase
   endfunction

   assign rise  = r.scl[1] & ~r.scl[2];
   assign fall  = ~r.scl[1] & r.scl[2];
   assign start = r.scl[1] & r.scl[2] & r.sda[2] & ~r.sda[1];
   assign stop  = r.scl[1] & r.scl[2] & ~r.sda[2] & r.sda[1];

   // --------------------------------------------------------------------
   // Link domain engine
   // --------------------------------------------------------------------
   always_comb begin
      n = r;
      setf = 8'h00;
      exec = 1'b0;
      clr = 1'b0;
      tb = 8'hff;
      ci = cinfo(r.cmd);
      cb = cinfo(r.sh);
      len = {1'b0, ci[1:0]};
      n.scl = {r.scl[1:0], scl_in};
      n.sda = {r.sda[1:0], sda_in};
      n.hs1 = high_address_strap_in;
      n.hs2 = r.hs1;
      n.ls1 = low_address_strap_in;
      n.ls2 = r.ls1;
      n.pw1 = nvm_password_in;
      n.pw2 = r.pw1;
      n.ak1 = m.ack;
      n.ak2 = r.ak1;
      if (r.ld != 2'h3) begin
         n.ld = r.ld + 2'h1;
         if (r.ld == 2'h2) begin
            n.pwd = r.pw2;
            n.locked = |r.pw2;
         end
      end
      case (r.cmd)
         CMD_PAGE:      wd = {8'h00, r.page};
         CMD_ST_VOUT:   wd = {8'h00, m.snap.st_vout};
         CMD_ST_IOUT:   wd = {8'h00, m.snap.st_iout};
         CMD_ST_IN:     wd = {8'h00, m.snap.st_in};
         CMD_ST_TEMP:   wd = {8'h00, m.snap.st_temp};
         CMD_ST_CML:    wd = {8'h00, r.cml};
         CMD_VIN:       wd = m.snap.vin;
         CMD_IIN:       wd = m.snap.iin;
         CMD_VOUT:      wd = m.snap.vout;
         CMD_IOUT:      wd = m.snap.iout;
         CMD_TEMP:      wd = m.snap.temp;
         CMD_POUT:      wd = m.snap.pout;
         CMD_PIN:       wd = m.snap.pin;
         CMD_PWD_STORE: wd = r.pwd;
         CMD_ADDR_CFG:  wd = r.acfg;
         CMD_BOOT_V:    wd = r.boot;
         default:       wd = 16'h0000;
      endcase
      if (start) begin
         n.st = S_BYTE;
         n.bcnt = 4'h8;                                                 // Absorbs SCL fall of START
         n.bidx = 3'h0;
         n.sda_oe = 1'b0;
         n.rd = 1'b0;
         n.req = ~r.req;
         if (!r.have_cmd) begin
            n.crc = 8'h00;
            n.ndata = 3'h0;
         end
      end else if (stop) begin
         if (r.st != S_IDLE && !r.rd && r.have_cmd) begin
            if (!ci[CI_WR]) begin
               setf[CML_CMD] = 1'b1;
            end else if (r.ndata == len) begin
               exec = 1'b1;
            end else if (r.ndata == len + 3'h1) begin
               if (r.crcp == r.last) begin
                  exec = 1'b1;
               end else begin
                  setf[CML_PEC] = 1'b1;
               end
            end else begin
               setf[CML_DATA] = 1'b1;
            end
         end
         n.st = S_IDLE;
         n.have_cmd = 1'b0;
         n.sda_oe = 1'b0;
         n.rd = 1'b0;
      end else if (rise && r.st == S_BYTE) begin
         if (r.bcnt < 4'h8) begin
            n.sh = {r.sh[6:0], r.sda[1]};
         end else begin
            n.mnack = r.sda[1];
         end
      end else if (fall && r.st == S_BYTE) begin
         if (r.bcnt == 4'h7) begin
            n.bcnt = 4'h8;
            n.sda_oe = 1'b0;
            if (r.bidx != 3'h7) begin
               n.bidx = r.bidx + 3'h1;
            end
            if (r.bidx == 3'h0) begin
               n.rd = r.sh[0];
               n.txi = 3'h0;
               if (r.sh[7:1] != r.addr && r.sh[7:1] != ALL_CALL) begin
                  n.st = S_SKIP;
               end else if (r.sh[0] && !r.have_cmd) begin
                  setf[CML_OTHER] = 1'b1;
                  n.st = S_SKIP;
               end else if (r.sh[0] && !ci[CI_RD]) begin
                  setf[CML_CMD] = 1'b1;
                  n.st = S_SKIP;
                  n.have_cmd = 1'b0;
               end else begin
                  n.sda_oe = 1'b1;
                  n.crc = crc8(r.crc, r.sh);
               end
            end else if (!r.rd) begin
               n.crcp = r.crc;
               n.crc = crc8(r.crc, r.sh);
               if (r.bidx == 3'h1) begin
                  n.cmd = r.sh;
                  if (!cb[CI_SUP] || (r.prot && cb[CI_PROT])) begin
                     setf[CML_CMD] = 1'b1;
                     n.st = S_SKIP;
                  end else begin
                     n.have_cmd = 1'b1;
                     n.sda_oe = 1'b1;
                  end
               end else if (r.ndata <= len) begin
                  n.ndata = r.ndata + 3'h1;
                  n.last = r.sh;
                  n.sda_oe = 1'b1;
                  if (r.ndata == 3'h0) begin
                     n.wbuf[7:0] = r.sh;
                  end else if (r.ndata == 3'h1) begin
                     n.wbuf[15:8] = r.sh;
                  end
               end else begin
                  setf[CML_DATA] = 1'b1;
                  n.st = S_SKIP;
                  n.have_cmd = 1'b0;
               end
            end
         end else if (r.bcnt == 4'h8) begin
            n.bcnt = 4'h0;
            n.sda_oe = 1'b0;
            if (r.rd && (r.txi == 3'h0 || !r.mnack)) begin
               if (r.txi < len) begin
                  tb = r.txi[0] ? wd[15:8] : wd[7:0];
                  n.crc = crc8(r.crc, tb);
               end else if (r.txi == len) begin
                  tb = r.crc;
               end else begin
                  setf[CML_DATA] = 1'b1;
               end
               n.txb = tb;
               if (r.txi != 3'h7) begin
                  n.txi = r.txi + 3'h1;
               end
               n.sda_oe = ~tb[7];
            end else if (r.rd) begin
               if (r.txi < len) begin
                  setf[CML_DATA] = 1'b1;
               end
               n.st = S_SKIP;
            end
         end else begin
            n.bcnt = r.bcnt + 4'h1;
            n.sda_oe = r.rd && r.txi != 3'h0 && !r.txb[3'(4'h6 - r.bcnt)];
         end
      end
      if (exec) begin
         case (r.cmd)
            CMD_PAGE:      n.page = r.wbuf[7:0];
            CMD_CLEAR:     clr = 1'b1;
            CMD_PWD_STORE: n.pwd = r.wbuf;
            CMD_ADDR_CFG: begin
               if (r.wbuf[ADDR_HI_MODE] && r.wbuf[ADDR_LO_MODE] && r.wbuf[6:0] == ALL_CALL) begin
                  setf[CML_DATA] = 1'b1;
               end else begin
                  n.acfg = r.wbuf;
               end
            end
            CMD_BOOT_V:    n.boot = r.wbuf;
            CMD_PWD_CHECK: begin
               if (r.wbuf == r.pwd) begin
                  n.locked = 1'b0;
               end
            end
            default: ;
         endcase
      end
      n.cml = (r.cml & ~{8{clr}}) | setf;
      n.hw = r.hs2[0];
      if (!n.acfg[ADDR_LO_MODE]) begin
         n.acfg[3:0] = r.ls2;
      end
      if (!n.acfg[ADDR_HI_MODE]) begin
         n.acfg[6:4] = r.hs2[3:1];
      end
      n.addr = n.acfg[6:0];
      n.prot = n.hw | n.locked;
      n.sda_o = 1'b0;
   end

   always_ff @(posedge link_clk_in or posedge rst_in) begin
      if (rst_in) begin
         r     <= '0;
         r.scl <= 3'h7;                                                 // Pins idle high
         r.sda <= 3'h7;
      end else begin
         r <= n;
      end
   end

   // --------------------------------------------------------------------
   // System domain: snapshot handshake and voltage scaling
   // --------------------------------------------------------------------
   always_comb begin
      mn = m;
      mn.alt1 = r.boot[BOOT_ALT];
      mn.alt2 = m.alt1;
      mn.rq1 = r.req;
      mn.rq2 = m.rq1;
      if (m.rq2 != m.ack) begin
         mn.snap = tele_in;
         mn.ack = m.rq2;
      end
      vid = {8'h00, m.snap.vout[7:0]};
      if (m.alt2) begin
         mn.vout_mv = (vid + VID_OFF_ALT) * STEP_10;
      end else begin
         mn.vout_mv = (vid + VID_OFF_STD) * (voltage_code_step_10mv_in ? STEP_10 : STEP_5);
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         m <= '0;
      end else begin
         m <= mn;
      end
   end

   assign sda_out            = r.sda_o;
   assign sda_oe_out         = r.sda_oe;
   assign device_address_out = r.addr;
   assign protect_active_out = r.prot;
   assign alt_table_out      = m.alt2;
   assign vout_mv_out        = m.vout_mv;

   // --------------------------------------------------------------------
   // Assertions
   // --------------------------------------------------------------------
   sequence s_byte_done;
      fall && r.st == S_BYTE && r.bcnt == 4'h7;
   endsequence
   property p_addr_match;
      @(posedge link_clk_in) disable iff (rst_in)
      s_byte_done and (r.bidx == 3'h0) |=> r.sda_oe |->
         ($past(r.sh[7:1]) == $past(r.addr) || $past(r.sh[7:1]) == ALL_CALL);
   endproperty
   a_addr_match: assert property (p_addr_match) else $error("ack on foreign address");
   property p_lo_strap;
      @(posedge link_clk_in) disable iff (rst_in)
      !n.acfg[ADDR_LO_MODE] |=> r.acfg[3:0] == $past(r.ls2);
   endproperty
   a_lo_strap: assert property (p_lo_strap) else $error("low nibble not from strap");
   property p_hi_strap;
      @(posedge link_clk_in) disable iff (rst_in)
      !n.acfg[ADDR_HI_MODE] |=> r.addr[6:4] == $past(r.hs2[3:1]);
   endproperty
   a_hi_strap: assert property (p_hi_strap) else $error("upper bits not from strap");
   property p_hw_strap;
      @(posedge link_clk_in) disable iff (rst_in)
      r.hs2[0] |=> r.hw && r.prot;
   endproperty
   a_hw_strap: assert property (p_hw_strap) else $error("odd strap level not protecting");
   property p_hw_prio;
      @(posedge link_clk_in) disable iff (rst_in)
      r.hw |-> r.prot;
   endproperty
   a_hw_prio: assert property (p_hw_prio) else $error("strap protection overridden");
   property p_unsup;
      @(posedge link_clk_in) disable iff (rst_in)
      s_byte_done and (r.bidx == 3'h1 && !r.rd && !cb[CI_SUP]) |=> r.cml[CML_CMD] && !r.sda_oe;
   endproperty
   a_unsup: assert property (p_unsup) else $error("unsupported command not flagged");
   property p_clear;
      @(posedge link_clk_in) disable iff (rst_in)
      clr && setf == 8'h00 |=> r.cml == 8'h00;
   endproperty
   a_clear: assert property (p_clear) else $error("faults not cleared");
   property p_pec_gate;
      @(posedge link_clk_in) disable iff (rst_in)
      exec |-> r.ndata == len || r.crcp == r.last;
   endproperty
   a_pec_gate: assert property (p_pec_gate) else $error("acted on bad check byte");
   property p_pec_bad;
      @(posedge link_clk_in) disable iff (rst_in)
      stop && setf[CML_PEC] |=> r.cml[CML_PEC] && $stable(r.pwd) && $stable(r.boot);
   endproperty
   a_pec_bad: assert property (p_pec_bad) else $error("check failure mishandled");
   property p_lock_hold;
      @(posedge link_clk_in) disable iff (rst_in)
      r.locked && !(exec && r.cmd == CMD_PWD_CHECK) |=> r.locked;
   endproperty
   a_lock_hold: assert property (p_lock_hold) else $error("lock released without match");
   property p_vid_alt;
      @(posedge mclk_in) disable iff (rst_in)
      m.alt2 |=> vout_mv_out == (16'($past(m.snap.vout[7:0])) + 16'd29) * 16'd10;
   endproperty
   a_vid_alt: assert property (p_vid_alt) else $error("alternate table scaling wrong");
endmodule

// ### tb/pmsp_host.sv
// Bus host model: drives SCL push-pull and pulls SDA low open-drain.
// Assumes the bench resolves SDA with a pull-up; steps on clk_in edges.
`timescale 1ns/1ns
module pmsp_host (
   input  wire logic clk_in,
   input  wire logic sda_in,
   output logic      scl_out,
   output logic      sda_pull_out
);
   logic [7:0] crc;
   int         qn;
   initial begin
      scl_out = 1'b1;
      sda_pull_out = 1'b0;
      crc = 8'h00;
      qn = 3;
   end
   // Quarter bit of qn 100 ns clocks: 3 about 833 kHz, 25 for 100 kHz
   task automatic q();
      repeat (qn) @(posedge clk_in);
   endtask
   // Also serves as repeated start
   task automatic start();
      sda_pull_out <= 1'b0;
      q();
      scl_out <= 1'b1;
      q();
      sda_pull_out <= 1'b1;
      q();
      scl_out <= 1'b0;
      q();
   endtask
   task automatic stop();
      sda_pull_out <= 1'b1;
      q();
      scl_out <= 1'b1;
      q();
      sda_pull_out <= 1'b0;
      q();
   endtask
   // Sends d and ninth bit m; returns bus byte r and ninth bit a
   task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] r,
                       output logic a);
      logic [8:0] v;
      v = {d, m};
      for (int i = 8; i >= 0; i--) begin
         sda_pull_out <= ~v[i];
         q();
         scl_out <= 1'b1;
         q();
         if (i > 0) r[i-1] = sda_in;
         else a = sda_in;
         q();
         scl_out <= 1'b0;
         q();
      end
      crc = crc ^ r;
      for (int k = 0; k < 8; k++)
         crc = crc[7] ? ({crc[6:0], 1'b0} ^ 8'h07) : {crc[6:0], 1'b0};
   endtask
endmodule

// ### tb/tb_pmsp_port.sv
// Bench for the serial slave port: rows of reads, then hand-written cases.
// Assumes pmsp_host as bus host and a pull-up on SDA.
`timescale 1ns/1ns
module tb_pmsp_port
   import pmsp_pkg::*;
;
   logic        mclk, lclk, rst, scl, pull, oe, sda_o, alt, prot, step10, ak;
   logic [3:0]  hs, ls;
   logic [15:0] pwd, vmv, v;
   logic [6:0]  dev, addr;
   logic [7:0]  rb;
   logic [31:0] rows [11];
   pmsp_tele_t  tele;
   int          error_cnt, checked;
   wire logic   sda = ~(oe | pull);
   pmsp_port DUT (.mclk_in(mclk), .rst_in(rst), .link_clk_in(lclk), .scl_in(scl),
      .sda_in(sda), .sda_out(sda_o), .sda_oe_out(oe), .high_address_strap_in(hs),
      .low_address_strap_in(ls), .nvm_password_in(pwd), .voltage_code_step_10mv_in(step10),
      .tele_in(tele), .device_address_out(dev), .protect_active_out(prot),
      .alt_table_out(alt), .vout_mv_out(vmv));
   pmsp_host host (.clk_in(mclk), .sda_in(sda), .scl_out(scl), .sda_pull_out(pull));
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic note(input string s);
      $display("test done: %s", s);
   endtask
   task automatic put(input logic [7:0] d);
      host.xfer(d, 1'b1, rb, ak);
   endtask
   // Writes n data bytes low first, then an optional check byte xored with x
   task automatic wr(input logic [7:0] c, input logic [15:0] d, input int n, input bit pec,
                     input logic [7:0] x);
      host.crc = 8'h00;
      host.start();
      put({addr, 1'b0});
      put(c);
      for (int i = 0; i < n; i++) put(d[8*i +: 8]);
      if (pec) put(host.crc ^ x);
      host.stop();
      repeat (2) @(posedge mclk);
   endtask
   task automatic rd(input logic [7:0] c, input int n, output logic [15:0] r);
      host.start();
      put({addr, 1'b0});
      put(c);
      host.start();
      put({addr, 1'b1});
      r = 16'h0000;
      for (int i = 0; i < n; i++) begin
         host.xfer(8'hff, i == n - 1, rb, ak);
         r[8*i +: 8] = rb;
      end
      host.stop();
   endtask
   task automatic do_reset();
      rst <= 1'b1;
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      repeat (5) @(posedge mclk);
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   initial begin
      lclk = 1'b0;
      #3;
      forever #6 lclk = ~lclk;
   end
   initial begin
      repeat (60000) @(posedge mclk);
      error_cnt++;
      wrap_up();
   end
   initial begin
      rst = 1'b1;
      hs = 4'h4;
      ls = 4'h5;
      pwd = 16'h0000;
      step10 = 1'b1;
      addr = 7'h25;
      error_cnt = 0;
      checked = 0;
      tele = '{vin: 16'h1111, iin: 16'h2222, vout: 16'h0064, iout: 16'h4444,
               temp: 16'h5555, pout: 16'h6666, pin: 16'h7777, st_vout: 8'h81,
               st_iout: 8'h42, st_in: 8'h24, st_temp: 8'h18};
      rows = '{32'h8802_1111, 32'h8902_2222, 32'h8b02_0064, 32'h8c02_4444, 32'h8d02_5555,
               32'h9602_6666, 32'h9702_7777, 32'h7a01_0081, 32'h7b01_0042, 32'h7c01_0024,
               32'h7d01_0018};
      do_reset();
      chk({9'h000, dev}, 16'h0025);
      chk({15'h0000, prot}, 16'h0000);
      chk({15'h0000, sda_o}, 16'h0000);
      for (int i = 0; i < 11; i++) begin
         rd(rows[i][31:24], int'(rows[i][23:16]), v);
         chk(v, rows[i][15:0]);
      end
      note("telemetry rows");
      chk(vmv, 16'h05d2);
      step10 <= 1'b0;
      repeat (4) @(posedge mclk);
      chk(vmv, 16'h02e9);
      step10 <= 1'b1;
      host.qn = 25;
      rd(CMD_VIN, 2, v);
      chk(v, 16'h1111);
      host.qn = 3;
      note("scaling and slow rate");
      host.start();
      put(8'h4c);
      chk({15'h0000, ak}, 16'h0001);
      host.stop();
      host.start();
      put(8'h00);
      chk({15'h0000, ak}, 16'h0000);
      host.stop();
      wr(CMD_CLEAR, 16'h0000, 0, 1'b0, 8'h00);
      wr(8'h55, 16'h0000, 0, 1'b0, 8'h00);
      chk({15'h0000, ak}, 16'h0001);
      wr(CMD_BOOT_V, 16'h0100, 1, 1'b0, 8'h00);
      rd(CMD_ST_CML, 1, v);
      chk(v, 16'h00c0);
      wr(CMD_CLEAR, 16'h0000, 0, 1'b0, 8'h00);
      rd(CMD_ST_CML, 1, v);
      chk(v, 16'h0000);
      note("faults");
      wr(CMD_BOOT_V, 16'h0100, 2, 1'b1, 8'h01);
      chk({15'h0000, alt}, 16'h0000);
      rd(CMD_ST_CML, 1, v);
      chk(v, 16'h0020);
      wr(CMD_BOOT_V, 16'h0100, 2, 1'b1, 8'h00);
      repeat (4) @(posedge mclk);
      chk({15'h0000, alt}, 16'h0001);
      chk(vmv, 16'h050a);
      note("check byte");
      wr(CMD_ADDR_CFG, 16'h01b1, 2, 1'b0, 8'h00);
      chk({9'h000, dev}, 16'h0031);
      addr = 7'h31;
      wr(CMD_ADDR_CFG, 16'h0180, 2, 1'b0, 8'h00);
      chk({9'h000, dev}, 16'h0031);
      note("address");
      hs <= 4'h5;
      repeat (2) @(posedge mclk);
      chk({15'h0000, prot}, 16'h0001);
      wr(CMD_BOOT_V, 16'h0000, 2, 1'b0, 8'h00);
      chk({15'h0000, alt}, 16'h0001);
      rd(CMD_ST_VOUT, 1, v);
      chk(v, 16'h0081);
      hs <= 4'h4;
      pwd <= 16'hbeef;
      do_reset();
      addr = 7'h25;
      chk({15'h0000, prot}, 16'h0001);
      wr(CMD_PWD_CHECK, 16'hbeee, 2, 1'b0, 8'h00);
      chk({15'h0000, prot}, 16'h0001);
      wr(CMD_PWD_CHECK, 16'hbeef, 2, 1'b0, 8'h00);
      chk({15'h0000, prot}, 16'h0000);
      hs <= 4'h5;
      repeat (2) @(posedge mclk);
      chk({15'h0000, prot}, 16'h0001);
      note("protection");
      wrap_up();
   end
endmodule
